// ===== reset_source_combiner_status.v
// Purpose: combine reset sources into one system reset and keep the reset cause word
// Assumes: reset source inputs are asynchronous levels; config inputs are static
// Notes: rst is the power-on reset of this block itself
`timescale 1ns/1ps
`include "rst_combiner_consts.vh"
module reset_source_combiner_status (
	input wire clk,
	input wire rst,
	input wire brown_out_req,
	input wire master_clear_pin_n,
	input wire soft_reset_req,
	input wire watchdog_timeout_req,
	input wire config_mismatch_req,
	input wire trap_conflict_req,
	input wire illegal_access_req,
	input wire sleep_wake,
	input wire idle_wake,
	input wire [2:0] initial_osc_select,
	input wire watchdog_config_enable,
	input wire [`RCS_ADDR_W-1:0] addr,
	input wire [15:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [15:0] rdata,
	output wire master_system_reset,
	output wire watchdog_enable,
	output wire flash_regulator_sleep_ctl,
	output wire main_regulator_sleep_ctl,
	output wire [2:0] new_osc_field
);
	// levels from detectors and pads are asynchronous to clk
	reg [`RCS_SRC_W-1:0] src_meta_ff;
	reg [`RCS_SRC_W-1:0] src_sync_ff;
	reg [`RCS_SRC_W-1:0] src_prev_ff;
	reg rst_seen_ff;
	reg por_flag_ff;
	reg brown_out_flag_ff;
	reg idle_flag_ff;
	reg sleep_flag_ff;
	reg watchdog_timeout_flag_ff;
	reg watchdog_soft_enable_ff;
	reg soft_reset_flag_ff;
	reg ext_pin_reset_flag_ff;
	reg main_regulator_sleep_ctl_ff;
	reg config_mismatch_flag_ff;
	reg flash_regulator_sleep_ctl_ff;
	reg illegal_access_flag_ff;
	reg trap_conflict_flag_ff;
	reg [`RCS_OSC_W-1:0] osc_sel_ff;
	reg nxt_por_flag;
	reg nxt_brown_out_flag;
	reg nxt_idle_flag;
	reg nxt_sleep_flag;
	reg nxt_watchdog_timeout_flag;
	reg nxt_watchdog_soft_enable;
	reg nxt_soft_reset_flag;
	reg nxt_ext_pin_reset_flag;
	reg nxt_main_regulator_sleep_ctl;
	reg nxt_config_mismatch_flag;
	reg nxt_flash_regulator_sleep_ctl;
	reg nxt_illegal_access_flag;
	reg nxt_trap_conflict_flag;
	reg [`RCS_OSC_W-1:0] nxt_osc_sel;
	reg [15:0] nxt_rdata;
	wire [`RCS_SRC_W-1:0] src_raw;
	wire [`RCS_SRC_W-1:0] src_rise;
	wire any_src;
	wire status_wr;
	wire [15:0] status_word;
	wire [15:0] osc_word;
	wire bor_set;
	wire watchdog_timeout_flag_set;
	wire swr_set;
	wire ext_pin_reset_flag_set;
	wire cm_set;
	wire iopu_set;
	wire trap_set;
	wire sleep_set;
	wire idle_set;

	// set wins: a cause in the cycle of a software clear still leaves its flag up
	function next_flag(input cur, input wr_hit, input wbit, input hw_set);
		next_flag = hw_set | (wr_hit ? wbit : cur);
	endfunction

	function is_status_addr(input [`RCS_ADDR_W-1:0] a);
		is_status_addr = (a == `RCS_ADDR_STATUS);
	endfunction

	function is_osc_addr(input [`RCS_ADDR_W-1:0] a);
		is_osc_addr = (a == `RCS_ADDR_OSC);
	endfunction

	function [15:0] pack_osc(input [`RCS_OSC_W-1:0] sel);
		pack_osc = `RCS_ZERO16 | (sel << `RCS_NEW_OSC_FIELD_LSB);
	endfunction

	// the clear pin is active low; every source is high here while active
	assign src_raw[`RCS_SRC_BOR] = brown_out_req;
	assign src_raw[`RCS_SRC_WATCHDOG_TIMEOUT_FLAG] = watchdog_timeout_req;
	assign src_raw[`RCS_SRC_SWR] = soft_reset_req;
	assign src_raw[`RCS_SRC_EXT_PIN_RESET_FLAG] = ~master_clear_pin_n;
	assign src_raw[`RCS_SRC_CM] = config_mismatch_req;
	assign src_raw[`RCS_SRC_IOPU] = illegal_access_req;
	assign src_raw[`RCS_SRC_TRAP] = trap_conflict_req;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			src_meta_ff <= `RCS_SRC_IDLE;
			src_sync_ff <= `RCS_SRC_IDLE;
			src_prev_ff <= `RCS_SRC_IDLE;
		end else begin
			src_meta_ff <= src_raw;
			src_sync_ff <= src_meta_ff;
			src_prev_ff <= src_sync_ff;
		end
	end

	// a held source sets its flag once, on the rise of its synced level
	assign src_rise = src_sync_ff & ~src_prev_ff;
	assign any_src = |src_sync_ff;
	assign master_system_reset = any_src | rst_seen_ff;

	// power-on counts as a one-cycle system reset after release
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_seen_ff <= `RCS_ON;
		end else begin
			rst_seen_ff <= `RCS_OFF;
		end
	end

	assign status_wr = wr_en & is_status_addr(addr);

	// wake pulses come from power control logic on clk, so no synchroniser
	assign bor_set = src_rise[`RCS_SRC_BOR];
	assign watchdog_timeout_flag_set = src_rise[`RCS_SRC_WATCHDOG_TIMEOUT_FLAG];
	assign swr_set = src_rise[`RCS_SRC_SWR];
	assign ext_pin_reset_flag_set = src_rise[`RCS_SRC_EXT_PIN_RESET_FLAG];
	assign cm_set = src_rise[`RCS_SRC_CM];
	assign iopu_set = src_rise[`RCS_SRC_IOPU];
	assign trap_set = src_rise[`RCS_SRC_TRAP];
	assign sleep_set = sleep_wake;
	assign idle_set = idle_wake;

	// the power-on flag has no hardware set besides rst itself
	always @* begin
		nxt_por_flag = next_flag(por_flag_ff, status_wr,
			wdata[`RCS_BIT_POR], `RCS_OFF);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			por_flag_ff <= `RCS_ON;
		end else begin
			por_flag_ff <= nxt_por_flag;
		end
	end

	always @* begin
		nxt_brown_out_flag = next_flag(brown_out_flag_ff, status_wr,
			wdata[`RCS_BIT_BOR], bor_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			brown_out_flag_ff <= `RCS_ON;
		end else begin
			brown_out_flag_ff <= nxt_brown_out_flag;
		end
	end

	always @* begin
		nxt_idle_flag = next_flag(idle_flag_ff, status_wr,
			wdata[`RCS_BIT_IDLE], idle_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_flag_ff <= `RCS_OFF;
		end else begin
			idle_flag_ff <= nxt_idle_flag;
		end
	end

	always @* begin
		nxt_sleep_flag = next_flag(sleep_flag_ff, status_wr,
			wdata[`RCS_BIT_SLEEP], sleep_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_flag_ff <= `RCS_OFF;
		end else begin
			sleep_flag_ff <= nxt_sleep_flag;
		end
	end

	always @* begin
		nxt_watchdog_timeout_flag = next_flag(watchdog_timeout_flag_ff, status_wr,
			wdata[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG], watchdog_timeout_flag_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			watchdog_timeout_flag_ff <= `RCS_OFF;
		end else begin
			watchdog_timeout_flag_ff <= nxt_watchdog_timeout_flag;
		end
	end

	always @* begin
		nxt_watchdog_soft_enable = next_flag(watchdog_soft_enable_ff, status_wr,
			wdata[`RCS_BIT_WATCHDOG_SOFT_ENABLE], `RCS_OFF);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			watchdog_soft_enable_ff <= `RCS_OFF;
		end else begin
			watchdog_soft_enable_ff <= nxt_watchdog_soft_enable;
		end
	end

	always @* begin
		nxt_soft_reset_flag = next_flag(soft_reset_flag_ff, status_wr,
			wdata[`RCS_BIT_SWR], swr_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			soft_reset_flag_ff <= `RCS_OFF;
		end else begin
			soft_reset_flag_ff <= nxt_soft_reset_flag;
		end
	end

	always @* begin
		nxt_ext_pin_reset_flag = next_flag(ext_pin_reset_flag_ff, status_wr,
			wdata[`RCS_BIT_EXT_PIN_RESET_FLAG], ext_pin_reset_flag_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_pin_reset_flag_ff <= `RCS_OFF;
		end else begin
			ext_pin_reset_flag_ff <= nxt_ext_pin_reset_flag;
		end
	end

	always @* begin
		nxt_main_regulator_sleep_ctl = next_flag(main_regulator_sleep_ctl_ff, status_wr,
			wdata[`RCS_BIT_MAIN_REGULATOR_SLEEP_CTL], `RCS_OFF);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			main_regulator_sleep_ctl_ff <= `RCS_OFF;
		end else begin
			main_regulator_sleep_ctl_ff <= nxt_main_regulator_sleep_ctl;
		end
	end

	always @* begin
		nxt_config_mismatch_flag = next_flag(config_mismatch_flag_ff, status_wr,
			wdata[`RCS_BIT_CM], cm_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			config_mismatch_flag_ff <= `RCS_OFF;
		end else begin
			config_mismatch_flag_ff <= nxt_config_mismatch_flag;
		end
	end

	always @* begin
		nxt_flash_regulator_sleep_ctl = next_flag(flash_regulator_sleep_ctl_ff, status_wr,
			wdata[`RCS_BIT_FLASH_REGULATOR_SLEEP_CTL], `RCS_OFF);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_regulator_sleep_ctl_ff <= `RCS_OFF;
		end else begin
			flash_regulator_sleep_ctl_ff <= nxt_flash_regulator_sleep_ctl;
		end
	end

	always @* begin
		nxt_illegal_access_flag = next_flag(illegal_access_flag_ff, status_wr,
			wdata[`RCS_BIT_IOPU], iopu_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			illegal_access_flag_ff <= `RCS_OFF;
		end else begin
			illegal_access_flag_ff <= nxt_illegal_access_flag;
		end
	end

	always @* begin
		nxt_trap_conflict_flag = next_flag(trap_conflict_flag_ff, status_wr,
			wdata[`RCS_BIT_TRAP], trap_set);
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			trap_conflict_flag_ff <= `RCS_OFF;
		end else begin
			trap_conflict_flag_ff <= nxt_trap_conflict_flag;
		end
	end

	// the config select is static, so it is copied without a synchroniser
	always @* begin
		nxt_osc_sel = osc_sel_ff;
		if (master_system_reset) begin
			nxt_osc_sel = initial_osc_select;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_sel_ff <= `RCS_OSC_RESET;
		end else begin
			osc_sel_ff <= nxt_osc_sel;
		end
	end

	assign osc_word = pack_osc(osc_sel_ff);
	// holes are not stored at all, so they cannot hold a written one
	assign status_word = {
		trap_conflict_flag_ff,
		illegal_access_flag_ff,
		`RCS_HOLE_HI,
		flash_regulator_sleep_ctl_ff,
		`RCS_OFF,
		config_mismatch_flag_ff,
		main_regulator_sleep_ctl_ff,
		ext_pin_reset_flag_ff,
		soft_reset_flag_ff,
		watchdog_soft_enable_ff,
		watchdog_timeout_flag_ff,
		sleep_flag_ff,
		idle_flag_ff,
		brown_out_flag_ff,
		por_flag_ff
	};

	// read data stand for one cycle only and are zero otherwise
	always @* begin
		nxt_rdata = `RCS_ZERO16;
		if (rd_en) begin
			if (is_status_addr(addr)) begin
				nxt_rdata = status_word;
			end else if (is_osc_addr(addr)) begin
				nxt_rdata = osc_word;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= `RCS_ZERO16;
		end else begin
			rdata <= nxt_rdata;
		end
	end

	assign new_osc_field = osc_sel_ff;
	assign watchdog_enable = watchdog_soft_enable_ff | watchdog_config_enable;
	assign flash_regulator_sleep_ctl = flash_regulator_sleep_ctl_ff;
	assign main_regulator_sleep_ctl = main_regulator_sleep_ctl_ff;
endmodule

// ===== reset_source_combiner_status_chk.sv
// Purpose: port-level checks of the reset combiner
// Assumes: sources pass two sync flops before acting
// Notes: bound to every instance of the combiner
`timescale 1ns/1ps
module reset_source_combiner_status_chk(
	input wire clk, input wire rst, input wire brown_out_req, input wire master_clear_pin_n,
	input wire soft_reset_req, input wire watchdog_timeout_req, input wire config_mismatch_req,
	input wire trap_conflict_req, input wire illegal_access_req, input wire watchdog_config_enable,
	input wire [2:0] initial_osc_select, input wire [3:0] addr, input wire [15:0] wdata,
	input wire wr_en, input wire rd_en, input wire [15:0] rdata, input wire master_system_reset,
	input wire watchdog_enable, input wire flash_regulator_sleep_ctl,
	input wire main_regulator_sleep_ctl, input wire [2:0] new_osc_field
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire src = brown_out_req | soft_reset_req | watchdog_timeout_req | ~master_clear_pin_n
		| config_mismatch_req | trap_conflict_req | illegal_access_req;
	// three idle cycles cover the sync latency, so a write alone is judged
	sequence quiet_wr; !src [*3] ##0 wr_en; endsequence
	sequence reg_wr; wr_en && addr == 4'h0; endsequence
	a_src_resets: assert property ($rose(brown_out_req) |-> ##[2:3] master_system_reset)
		else $error("source gave no system reset");
	a_sw_noreset: assert property (quiet_wr |=> !master_system_reset)
		else $error("register write caused a reset");
	a_osc_load: assert property ($fell(master_system_reset) |-> new_osc_field == initial_osc_select)
		else $error("oscillator select not loaded");
	a_flash_reg: assert property (reg_wr |=> flash_regulator_sleep_ctl == $past(wdata[11]))
		else $error("flash regulator control wrong");
	a_main_reg: assert property (reg_wr |=> main_regulator_sleep_ctl == $past(wdata[8]))
		else $error("main regulator control wrong");
	a_wdt_forced: assert property (watchdog_config_enable |-> watchdog_enable)
		else $error("watchdog not forced on");
	a_wdt_soft: assert property (reg_wr |=> watchdog_enable == ($past(wdata[5]) | watchdog_config_enable))
		else $error("watchdog enable wrong");
	a_hole_zero: assert property ((rd_en && addr == 4'h0) |=> rdata[13:12] == 2'h0 && !rdata[10])
		else $error("unimplemented bits read nonzero");
endmodule
bind reset_source_combiner_status reset_source_combiner_status_chk u_chk(.*);

// ===== reset_src_model.sv
// Purpose: upstream reset detectors, each a level held for a random span
// Assumes: req is a one-cycle command per detector
// Notes: hold of 1 to 8 cycles gives prompt and slow releases
`timescale 1ns/1ps
module reset_src_model(
	input wire clk,
	input wire [6:0] req,
	output reg [6:0] lvl
);
	int n = 0;
	initial lvl = 7'h00;
	always @(posedge clk) begin
		if (req != 7'h00) begin
			lvl <= req;
			n <= 1 + $urandom % 8;
		end else if (n > 1) n <= n - 1;
		else lvl <= 7'h00;
	end
endmodule

// ===== rst_combiner_consts.vh
// Purpose: constants for the reset source combiner and its status register
// Assumes: 16-bit status word, plain register port
// Notes: bit positions and offsets used by reset_source_combiner_status
`ifndef RST_COMBINER_CONSTS_VH
`define RST_COMBINER_CONSTS_VH
`define RCS_ADDR_W 4
`define RCS_ADDR_STATUS 4'h0
`define RCS_ADDR_OSC 4'h1
`define RCS_BIT_POR 0
`define RCS_BIT_BOR 1
`define RCS_BIT_IDLE 2
`define RCS_BIT_SLEEP 3
`define RCS_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_BIT_WATCHDOG_SOFT_ENABLE 5
`define RCS_BIT_SWR 6
`define RCS_BIT_EXT_PIN_RESET_FLAG 7
`define RCS_BIT_MAIN_REGULATOR_SLEEP_CTL 8
`define RCS_BIT_CM 9
`define RCS_BIT_FLASH_REGULATOR_SLEEP_CTL 11
`define RCS_BIT_IOPU 14
`define RCS_BIT_TRAP 15
`define RCS_IMPL_MASK 16'hCBFF
`define RCS_POR_VALUE 16'h0003
`define RCS_NEW_OSC_FIELD_LSB 8
`define RCS_NEW_OSC_FIELD_MSB 10
`define RCS_ZERO16 16'h0000
`define RCS_SRC_W 7
`define RCS_SRC_BOR 0
`define RCS_SRC_WATCHDOG_TIMEOUT_FLAG 1
`define RCS_SRC_SWR 2
`define RCS_SRC_EXT_PIN_RESET_FLAG 3
`define RCS_SRC_CM 4
`define RCS_SRC_IOPU 5
`define RCS_SRC_TRAP 6
`define RCS_SRC_IDLE 7'h00
`define RCS_OSC_W 3
`define RCS_OSC_RESET 3'h0
`define RCS_HOLE_HI 2'h0
`define RCS_ON 1'b1
`define RCS_OFF 1'b0
`endif

// ===== test_reset_source_combiner_status.sv
// Purpose: self-checking bench for the reset combiner
// Assumes: status at 0x0, osc control at 0x1
// Notes: each source is fired alone after clearing the word, then all together
`timescale 1ns/1ps
module test_reset_source_combiner_status;
	reg clk = 0, rst = 1, wr_en = 0, rd_en = 0, rdp = 0, slp = 0, idl = 0, wcfg = 0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	reg [2:0] osc = 3'h0;
	reg [6:0] req = 7'h00;
	wire [6:0] lvl;
	wire [15:0] rdata;
	wire msr;
	int error_cnt = 0, check_count = 0, cyc = 0;
	int bt[7] = '{1, 7, 6, 4, 9, 15, 14};
	logic [15:0] q[$], e, rv;
	always #12.5 clk = ~clk;
	reset_src_model m(.clk(clk), .req(req), .lvl(lvl));
	reset_source_combiner_status DUT(.clk(clk), .rst(rst), .brown_out_req(lvl[0]),
		.master_clear_pin_n(~lvl[1]), .soft_reset_req(lvl[2]), .watchdog_timeout_req(lvl[3]),
		.config_mismatch_req(lvl[4]), .trap_conflict_req(lvl[5]), .illegal_access_req(lvl[6]),
		.sleep_wake(slp), .idle_wake(idl), .initial_osc_select(osc), .watchdog_config_enable(wcfg),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.master_system_reset(msr), .watchdog_enable(), .flash_regulator_sleep_ctl(),
		.main_regulator_sleep_ctl(), .new_osc_field());
	task results;
		if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1; end
		@(posedge clk) wr_en <= 0;
	endtask
	task rd(input [3:0] a, input [15:0] x);
		@(posedge clk) begin addr <= a; rd_en <= 1; q.push_back(x); end
		@(posedge clk) rd_en <= 0;
	endtask
	task src(input [6:0] r, input [15:0] x);
		wr(4'h0, 16'h0000);
		@(posedge clk) req <= r;
		@(posedge clk) req <= 7'h00;
		repeat (4) @(posedge clk);
		while (msr !== 1'b0) @(posedge clk);
		rd(4'h0, x);
	endtask
	always @(posedge clk) begin
		rdp <= rd_en;
		cyc <= cyc + 1;
		if (cyc > 3000) begin error_cnt++; results; end
		else if (rdp) begin
			e = q.pop_front();
			check_count++;
			if (rdata !== e) begin error_cnt++; $display("[ERR] rdata exp %h got %h", e, rdata); end
		end
	end
	initial begin
		e = $urandom(13);
		osc = $urandom;
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rd(4'h0, 16'h0003);
		rd(4'h1, {5'h00, osc, 8'h00});
		rd(4'h2, 16'h0000);
		for (int i = 0; i < 7; i++) src(7'h01 << i, 16'h0001 << bt[i]);
		osc <= ~osc;
		src(7'h7F, 16'hC2D2);
		rd(4'h1, {5'h00, osc, 8'h00});
		wr(4'h0, 16'h0000);
		@(posedge clk) slp <= 1;
		@(posedge clk) begin slp <= 0; idl <= 1; end
		@(posedge clk) idl <= 0;
		rd(4'h0, 16'h000C);
		repeat (6) begin
			rv = $urandom;
			wcfg <= $urandom;
			wr(4'h0, rv);
			rd(4'h0, rv & 16'hCBFF);
		end
		@(posedge clk) rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rd(4'h0, 16'h0003);
		rd(4'h1, {5'h00, osc, 8'h00});
		repeat (3) @(posedge clk);
		results;
	end
endmodule
